// ### design/bis_top.sv
// Board interrupt subsystem: strap matrix, priority unit and support logic.
// Notes on behaviour
// [R1] Nine levels: a direct non-maskable line plus eight arbitrated levels.
// [R2] Fully nested mode: level 0 highest, level 7 lowest.
// [R3] Rotating mode: a serviced level becomes lowest until the next one.
// [R4] Specific mode: software names the lowest level; others follow in order.
// [R5] Polled mode: no processor interrupt; software reads encoded status.
// [R6] Mode and priorities may change at any time without reset.
// [R7] One mask byte masks any combination of the eight levels.
// [R8] Accept all sources, resolve by mode, interrupt only when warranted.
// [R9] Slave units on the system bus cascade to reach 65 levels.
// [R10] Twenty-eight sources strap to any level or to non-maskable line.
// [R11] Bus timer requests an interrupt after 6 ms without bus answer.
// [R12] Low memory-protect input blocks all on-board RAM access.
// [R13] Power-fail request accepted together with the mains-low warning.
// [R14] Edge-to-level converter turns an edge into a level request.
// [R15] Two OR gates each combine several sources into one request.
// [R16] Parallel port gives three sources incl. socket general request.
// [R17] Serial interface gives transmit-empty and receive-full sources.
// [R18] Counter 0 and 1 outputs act as two sources.
// [R19] The 120 Hz line clock is one strappable source.
// [R20] Bus arbitration supports daisy chain and parallel, up to 16 masters.
// [R21] Converted level holds until acknowledged or reset; acknowledge clears it only via a direct strap, not an OR gate.
`timescale 1ns/100ps
module bis_top #(
  parameter int TOUT_CYC = bis_pkg::BIS_TOUT_CYC
) (
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register bus write channels
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // Register bus read channels
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Request sources
  input wire logic [7:0] bus_irq_i,
  input wire logic par_in_full_i,
  input wire logic par_out_empty_i,
  input wire logic socket_general_request_i,
  input wire logic ser_tx_empty_i,
  input wire logic ser_rx_full_i,
  input wire logic [1:0] timer_out_i,
  input wire logic [3:0] exp_irq_i,
  input wire logic power_fail_req_i,
  input wire logic mains_low_warning_i,
  input wire logic line_clk_i,
  input wire logic ext_irq_i,
  input wire logic numeric_err_i,
  input wire logic edge_req_i,
  input wire logic spare_irq_i,
  // Bus command watch
  input wire logic bus_cmd_i,
  input wire logic bus_xack_i,
  // Processor side
  output logic int_o,
  output logic nmi_o,
  input wire logic inta_i,
  output logic [7:0] vector_o,
  output logic vector_valid_o,
  output logic cas_en_o,
  output logic [2:0] cas_addr_o,
  // Memory protect
  input wire logic mem_protect_n_i,
  input wire logic ram_req_i,
  output logic ram_en_o,
  // Bus arbitration
  input wire logic arb_req_i,
  input wire logic bus_prio_in_n_i,
  input wire logic bus_busy_n_i,
  output logic bus_req_n_o,
  output logic bus_prio_out_n_o,
  output logic arb_grant_o
);
  import bis_pkg::*;

  if (TOUT_CYC < 2 || TOUT_CYC >= 2 ** BIS_TCNT_W) begin : g_chk
    $error("TOUT_CYC out of range for the timeout counter.");
  end

  bis_state_t s;
  bis_state_t next_s;
  bis_prio_if pr ();
  logic [BIS_NBASE-1:0] src_base;
  logic [BIS_NSRC-1:0] src;
  logic [BIS_NLVL-1:0] req;
  logic edge_lvl;
  logic edge_clr;
  logic or0;
  logic or1;
  logic pfail;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic [7:0] waddr;
  logic [31:0] wd;
  logic [3:0] wst;
  logic eoi_fire;
  logic ack;
  logic poll_ack;
  logic [5:0] widx;
  logic [5:0] ridx;

  function automatic logic [31:0] bis_merge(input logic [31:0] o,
                                            input logic [31:0] d,
                                            input logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (o & ~m) | (d & m);
  endfunction

  bis_edge u_edge (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .edge_i(edge_req_i),
    .clr_i(edge_clr),
    .level_o(edge_lvl)
  );

  bis_prio u_prio (
    .p(pr)
  );

  // Source assembly; OR gates only see the plain sources, so no loop forms.
  assign pfail = power_fail_req_i & mains_low_warning_i; // [R13]
  assign src_base = {edge_lvl, numeric_err_i, ext_irq_i, line_clk_i, // [R19]
                     pfail, s.tout, exp_irq_i, timer_out_i, // [R18]
                     ser_rx_full_i, ser_tx_empty_i, // [R17]
                     socket_general_request_i, par_out_empty_i, // [R16]
                     par_in_full_i, bus_irq_i};
  assign or0 = |(src_base & s.orsel[0]); // [R15]
  assign or1 = |(src_base & s.orsel[1]); // [R15]
  assign src = {spare_irq_i, or1, or0, src_base};

  // Strap matrix: each level and the direct line see any source set.
  for (genvar g = 0; g < BIS_NLVL; g++) begin : g_route
    assign req[g] = |(src & s.route[g]); // [R10]
  end
  assign nmi_o = |(src & s.route[BIS_NROUTE-1]); // [R1] [R10]

  assign pr.req = req & ~s.mask; // [R7]
  assign pr.isr = s.isr;
  assign pr.base = (s.mode == BIS_NESTED) ? 3'h0 : s.lowest + 3'h1; // [R4]
  assign int_o = pr.beats && (s.mode != BIS_POLLED); // [R5] [R8]

  // Register bus handshakes: one write and one read in flight at most.
  assign s_axi_awready_o = !s.aw_got && !s.bvalid;
  assign s_axi_wready_o = !s.w_got && !s.bvalid;
  assign s_axi_arready_o = !s.rvalid;
  assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_go = (s.aw_got || aw_hs) && (s.w_got || w_hs);
  assign waddr = s.aw_got ? s.awaddr : s_axi_awaddr_i;
  assign wd = s.w_got ? s.wdata : s_axi_wdata_i;
  assign wst = s.w_got ? s.wstrb : s_axi_wstrb_i;
  assign widx = waddr[7:2];
  assign ridx = s_axi_araddr_i[7:2];
  assign eoi_fire = wr_go && {widx, 2'b00} == BIS_EOI_OFS;

  // Acknowledge by processor cycle, or by a poll register read with a request pending, in any mode.
  assign poll_ack = ar_hs && {ridx, 2'b00} == BIS_POLL_OFS && pr.found;
  assign ack = (inta_i && int_o) || poll_ack; // [R5]
  assign edge_clr = ack && s.route[pr.lvl][BIS_SRC_EDGE]; // [R21]

  always_comb begin
    next_s = s;
    next_s.vec_valid = 1'b0;
    next_s.cas_en = 1'b0;
    if (aw_hs) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr_i;
    end
    if (w_hs) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata_i;
      next_s.wstrb = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    // In-service end first, so an acknowledge in the same cycle still sets.
    if (eoi_fire && pr.isr_any) begin
      next_s.isr[pr.isr_lvl] = 1'b0;
      if (s.mode == BIS_ROTATE) begin
        next_s.lowest = pr.isr_lvl; // [R3]
      end
    end
    if (wr_go) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = BIS_RESP_OK;
      case ({widx, 2'b00})
        BIS_CTRL_OFS: begin
          // Takes effect on the next cycle, no reset needed.
          if (wst[0]) begin
            next_s.mode = bis_mode_t'(wd[BIS_CTRL_MODE_LSB +: 2]); // [R6]
            next_s.lowest = wd[BIS_CTRL_LOW_LSB +: 3]; // [R4] [R6]
            next_s.arb_par = wd[BIS_CTRL_PAR_BIT]; // [R20]
          end
          if (wst[1]) begin
            next_s.vbase = wd[BIS_CTRL_VB_LSB +: 8];
          end
        end
        BIS_MASK_OFS: begin
          if (wst[0]) begin
            next_s.mask = wd[7:0]; // [R7]
          end
        end
        BIS_STAT_OFS: begin
          if (wst[2] && wd[BIS_STAT_TOUT_BIT]) begin
            next_s.tout = 1'b0;
          end
        end
        BIS_EOI_OFS: begin
          next_s.bresp = BIS_RESP_OK;
        end
        BIS_CASC_OFS: begin
          if (wst[0]) begin
            next_s.casc = wd[7:0]; // [R9]
          end
        end
        BIS_OR0_OFS: begin
          next_s.orsel[0] = 25'(bis_merge(32'(s.orsel[0]), wd, wst));
        end
        BIS_OR1_OFS: begin
          next_s.orsel[1] = 25'(bis_merge(32'(s.orsel[1]), wd, wst));
        end
        default: begin
          if (widx >= BIS_ROUTE_OFS[7:2] &&
              widx < BIS_ROUTE_OFS[7:2] + 6'(BIS_NROUTE)) begin
            next_s.route[4'(widx - BIS_ROUTE_OFS[7:2])] = 28'(bis_merge(
              32'(s.route[4'(widx - BIS_ROUTE_OFS[7:2])]), wd, wst));
          end else begin
            next_s.bresp = BIS_RESP_ERR;
          end
        end
      endcase
    end
    if (ar_hs) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = BIS_RESP_OK;
      next_s.rdata = '0;
      case ({ridx, 2'b00})
        BIS_CTRL_OFS: begin
          next_s.rdata[BIS_CTRL_MODE_LSB +: 2] = s.mode;
          next_s.rdata[BIS_CTRL_LOW_LSB +: 3] = s.lowest;
          next_s.rdata[BIS_CTRL_PAR_BIT] = s.arb_par;
          next_s.rdata[BIS_CTRL_VB_LSB +: 8] = s.vbase;
        end
        BIS_MASK_OFS: next_s.rdata[7:0] = s.mask;
        BIS_POLL_OFS: begin
          next_s.rdata[BIS_POLL_VLD_BIT] = pr.found; // [R5]
          next_s.rdata[2:0] = pr.lvl; // [R5]
        end
        BIS_STAT_OFS: begin
          next_s.rdata[7:0] = req;
          next_s.rdata[BIS_STAT_ISR_LSB +: 8] = s.isr;
          next_s.rdata[BIS_STAT_TOUT_BIT] = s.tout;
        end
        BIS_EOI_OFS: next_s.rdata = '0;
        BIS_CASC_OFS: next_s.rdata[7:0] = s.casc;
        BIS_OR0_OFS: next_s.rdata[24:0] = s.orsel[0];
        BIS_OR1_OFS: next_s.rdata[24:0] = s.orsel[1];
        default: begin
          if (ridx >= BIS_ROUTE_OFS[7:2] &&
              ridx < BIS_ROUTE_OFS[7:2] + 6'(BIS_NROUTE)) begin
            next_s.rdata[27:0] = s.route[4'(ridx - BIS_ROUTE_OFS[7:2])];
          end else begin
            next_s.rresp = BIS_RESP_ERR;
          end
        end
      endcase
    end
    if (ack) begin
      next_s.isr[pr.lvl] = 1'b1; // [R8]
      next_s.vector = s.vbase | {5'h00, pr.lvl};
      next_s.vec_valid = !poll_ack;
      // A cascaded level hands the vector cycle to the slave unit.
      next_s.cas_en = s.casc[pr.lvl] && !poll_ack; // [R9]
      next_s.cas_addr = pr.lvl; // [R9]
    end
    // Stalled bus command counter; the timeout flag wins over its clear.
    if (bus_cmd_i && !bus_xack_i) begin
      if (s.tcnt == BIS_TCNT_W'(TOUT_CYC - 1)) begin
        next_s.tout = 1'b1; // [R11]
      end else begin
        next_s.tcnt = s.tcnt + 21'h000001; // [R11]
      end
    end else begin
      next_s.tcnt = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= BIS_STATE_RST;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = s.rresp;
  assign vector_o = s.vector;
  assign vector_valid_o = s.vec_valid;
  assign cas_en_o = s.cas_en;
  assign cas_addr_o = s.cas_addr;

  // Protect input gates RAM strobes combinationally, so no access slips in.
  assign ram_en_o = ram_req_i && mem_protect_n_i; // [R12]

  // Daisy chain passes priority on; in parallel mode a decoder grants.
  assign bus_req_n_o = !arb_req_i; // [R20]
  assign bus_prio_out_n_o = s.arb_par || bus_prio_in_n_i || arb_req_i;
  assign arb_grant_o = arb_req_i && !bus_prio_in_n_i && bus_busy_n_i;

  property p_nested;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s.mode == BIS_NESTED && pr.req[0] && s.isr == 8'h00
        |-> int_o && pr.lvl == 3'h0;
  endproperty
  a_nested: assert property (p_nested) // [R2]
    else $error("Level 0 not first in nested mode.");

  property p_rotate;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && eoi_fire && pr.isr_any && s.mode == BIS_ROTATE
        |=> s.lowest == $past(pr.isr_lvl);
  endproperty
  a_rotate: assert property (p_rotate) // [R3]
    else $error("Serviced level did not become lowest.");

  property p_specific;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s.mode == BIS_SPECIFIC && s.isr == 8'h00 &&
        pr.req[s.lowest + 3'h1] |-> pr.lvl == s.lowest + 3'h1;
  endproperty
  a_specific: assert property (p_specific) // [R4]
    else $error("Level after lowest not ranked first.");

  property p_polled;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s.mode == BIS_POLLED |-> !int_o;
  endproperty
  a_polled: assert property (p_polled) // [R5]
    else $error("Interrupt raised in polled mode.");

  property p_mask;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      int_o |-> (req & ~s.mask & (8'h01 << pr.lvl)) != 8'h00;
  endproperty
  a_mask: assert property (p_mask) // [R7]
    else $error("Interrupt raised for a masked level.");

  property p_ack;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && inta_i && int_o |=> s.isr[$past(pr.lvl)] && s.vec_valid;
  endproperty
  a_ack: assert property (p_ack) // [R8]
    else $error("Acknowledge did not set in-service and vector.");

  property p_tout;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i && bus_cmd_i && !bus_xack_i &&
        s.tcnt == BIS_TCNT_W'(TOUT_CYC - 1) |=> s.tout;
  endproperty
  a_tout: assert property (p_tout) // [R11]
    else $error("Bus timeout flag not set at expiry.");

  property p_protect;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !mem_protect_n_i |-> !ram_en_o;
  endproperty
  a_protect: assert property (p_protect) // [R12]
    else $error("RAM enabled while protected.");

  property p_pfail;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      power_fail_req_i && !mains_low_warning_i |-> !src[20];
  endproperty
  a_pfail: assert property (p_pfail) // [R13]
    else $error("Power fail source without mains low warning.");
endmodule // bis_top

// ### design/bis_pkg.sv
// Shared constants, types and register map of the board interrupt subsystem.
package bis_pkg;
  localparam int BIS_CLK_KHZ = 250000;
  localparam int BIS_TOUT_MS = 6;
  localparam int BIS_TOUT_CYC = BIS_TOUT_MS * BIS_CLK_KHZ;
  localparam int BIS_TCNT_W = 21;
  localparam int BIS_NLVL = 8;
  localparam int BIS_LW = 3;
  localparam int BIS_NSRC = 28;
  localparam int BIS_NBASE = 25;
  localparam int BIS_NROUTE = 9;
  localparam int BIS_SRC_EDGE = 24;
  localparam logic [7:0] BIS_CTRL_OFS = 8'h00;
  localparam logic [7:0] BIS_MASK_OFS = 8'h04;
  localparam logic [7:0] BIS_POLL_OFS = 8'h08;
  localparam logic [7:0] BIS_STAT_OFS = 8'h0c;
  localparam logic [7:0] BIS_EOI_OFS = 8'h10;
  localparam logic [7:0] BIS_CASC_OFS = 8'h14;
  localparam logic [7:0] BIS_OR0_OFS = 8'h18;
  localparam logic [7:0] BIS_OR1_OFS = 8'h1c;
  localparam logic [7:0] BIS_ROUTE_OFS = 8'h20;
  localparam int BIS_CTRL_MODE_LSB = 0;
  localparam int BIS_CTRL_LOW_LSB = 2;
  localparam int BIS_CTRL_PAR_BIT = 5;
  localparam int BIS_CTRL_VB_LSB = 8;
  localparam int BIS_POLL_VLD_BIT = 7;
  localparam int BIS_STAT_ISR_LSB = 8;
  localparam int BIS_STAT_TOUT_BIT = 16;
  localparam logic [7:0] BIS_MASK_RST = 8'hff;
  localparam logic [1:0] BIS_RESP_OK = 2'h0;
  localparam logic [1:0] BIS_RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    BIS_NESTED = 2'b00,
    BIS_ROTATE = 2'b01,
    BIS_SPECIFIC = 2'b10,
    BIS_POLLED = 2'b11
  } bis_mode_t;

  typedef struct packed {
    bis_mode_t mode;
    logic [2:0] lowest;
    logic arb_par;
    logic [7:0] vbase;
    logic [7:0] mask;
    logic [7:0] casc;
    logic [7:0] isr;
    logic [1:0][24:0] orsel;
    logic [8:0][27:0] route;
    logic tout;
    logic [20:0] tcnt;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] vector;
    logic vec_valid;
    logic cas_en;
    logic [2:0] cas_addr;
  } bis_state_t;

  localparam bis_state_t BIS_STATE_RST = '{
    mode: BIS_NESTED, mask: BIS_MASK_RST, default: '0};

  typedef struct packed {
    logic prev;
    logic lvl;
  } bis_edge_st_t;
endpackage

// ### design/bis_prio_if.sv
// Carrier between the top module and the priority resolver.
`timescale 1ns/100ps
interface bis_prio_if;
  import bis_pkg::*;
  logic [BIS_NLVL-1:0] req;
  logic [BIS_NLVL-1:0] isr;
  logic [BIS_LW-1:0] base;
  logic found;
  logic beats;
  logic [BIS_LW-1:0] lvl;
  logic isr_any;
  logic [BIS_LW-1:0] isr_lvl;
  modport ctl (output req, isr, base,
               input found, beats, lvl, isr_any, isr_lvl);
  modport res (input req, isr, base,
               output found, beats, lvl, isr_any, isr_lvl);
endinterface

// ### design/bis_prio.sv
// Priority resolver ranking request and in-service levels from a base.
`timescale 1ns/100ps
module bis_prio (
  // Resolver carrier
  bis_prio_if.res p
);
  import bis_pkg::*;
  logic [BIS_LW-1:0] rank [BIS_NLVL];
  logic [BIS_LW-1:0] best;
  logic [BIS_LW-1:0] ibest;
  logic found;
  logic isr_any;
  logic [BIS_LW-1:0] lvl;
  logic [BIS_LW-1:0] isr_lvl;

  // The base level ranks first and the rank wraps round modulo eight.
  for (genvar g = 0; g < BIS_NLVL; g++) begin : g_rank
    assign rank[g] = BIS_LW'(g) - p.base; // [R2] [R3] [R4]
  end

  always_comb begin
    found = 1'b0;
    isr_any = 1'b0;
    best = '1;
    ibest = '1;
    lvl = '0;
    isr_lvl = '0;
    for (int i = 0; i < BIS_NLVL; i++) begin
      if (p.req[i] && (!found || rank[i] < best)) begin
        found = 1'b1;
        best = rank[i];
        lvl = BIS_LW'(i);
      end
      if (p.isr[i] && (!isr_any || rank[i] < ibest)) begin
        isr_any = 1'b1;
        ibest = rank[i];
        isr_lvl = BIS_LW'(i);
      end
    end
  end

  // A request only goes out when it outranks everything in service.
  assign p.beats = found && (!isr_any || best < ibest); // [R8]
  assign p.found = found;
  assign p.lvl = lvl;
  assign p.isr_any = isr_any;
  assign p.isr_lvl = isr_lvl;
endmodule // bis_prio

// ### design/bis_edge.sv
// Edge-to-level converter that holds a captured edge until acknowledged.
`timescale 1ns/100ps
module bis_edge (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Request path
  input wire logic edge_i,
  input wire logic clr_i,
  output logic level_o
);
  import bis_pkg::*;
  bis_edge_st_t s;
  bis_edge_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.prev = edge_i;
    if (clr_i) begin
      next_s.lvl = 1'b0; // [R21]
    end
    if (edge_i && !s.prev) begin
      next_s.lvl = 1'b1; // [R14]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign level_o = s.lvl;

  property p_edge_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s.lvl && !clr_i |=> s.lvl;
  endproperty
  a_edge_hold: assert property (p_edge_hold) // [R21]
    else $error("Level request dropped without acknowledge.");
endmodule // bis_edge

// ### sim/bis_cpu_model.sv
// Processor model that answers interrupt requests with acknowledge pulses.
`timescale 1ns/100ps
module bis_cpu_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Interrupt line and acknowledge
  input wire logic int_i,
  input wire logic en_i,
  output logic inta_o,
  // Vector returned by the block
  input wire logic vld_i,
  input wire logic [7:0] vec_i,
  input wire logic cas_i,
  output logic [7:0] vec_o,
  output logic cas_o,
  output int acks_o
);
  logic [1:0] cnt;
  // The wait follows the ack count, so prompt and slow answers both occur.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inta_o <= 1'b0;
      cnt <= 2'h0;
      acks_o <= 0;
      vec_o <= 8'h00;
      cas_o <= 1'b0;
    end else begin
      inta_o <= en_i && int_i && !inta_o && cnt == 2'(acks_o);
      cnt <= (en_i && int_i && !inta_o) ? cnt + 2'h1 : 2'h0;
      if (vld_i) begin
        vec_o <= vec_i;
        cas_o <= cas_i;
        acks_o <= acks_o + 1;
      end
    end
  end
endmodule // bis_cpu_model

// ### sim/bis_top_test.sv
// Self-checking testbench of the board interrupt subsystem.
`timescale 1ns/100ps
module bis_top_test;
  import bis_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic en = 1'b0, ml = 1'b0, cmd = 1'b0, xa = 1'b0, brn, gnt;
  logic [2:0] ca;
  logic [7:0] awa = 8'h00, ara = 8'h00, vec, mvec;
  logic [31:0] wd = 32'h0, rdat, rx;
  logic [27:0] src = 28'h0;
  logic awr, wrr, bv, arr, rv, irq, nmi, inta, vv, cen, ram_en, po_n, mcas;
  logic [1:0] br, rr, resp;
  int acks, na = 0, error_cnt = 0, checks_done = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  bis_top #(.TOUT_CYC(20)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .bus_irq_i(src[7:0]),
    .par_in_full_i(src[8]), .par_out_empty_i(src[9]),
    .socket_general_request_i(src[10]), .ser_tx_empty_i(src[11]),
    .ser_rx_full_i(src[12]), .timer_out_i(src[14:13]),
    .exp_irq_i(src[18:15]), .power_fail_req_i(src[20]),
    .mains_low_warning_i(ml), .line_clk_i(src[21]), .ext_irq_i(src[22]),
    .numeric_err_i(src[23]), .edge_req_i(src[24]), .spare_irq_i(src[27]),
    .bus_cmd_i(cmd), .bus_xack_i(xa), .int_o(irq), .nmi_o(nmi),
    .inta_i(inta), .vector_o(vec), .vector_valid_o(vv), .cas_en_o(cen),
    .cas_addr_o(ca), .mem_protect_n_i(!src[25]), .ram_req_i(1'b1),
    .ram_en_o(ram_en), .arb_req_i(src[26]), .bus_prio_in_n_i(src[19]),
    .bus_busy_n_i(1'b1), .bus_req_n_o(brn), .bus_prio_out_n_o(po_n),
    .arb_grant_o(gnt));
  bis_cpu_model i_cpu (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .int_i(irq), .en_i(en), .inta_o(inta), .vld_i(vv), .vec_i(vec),
    .cas_i(cen), .vec_o(mvec), .cas_o(mcas), .acks_o(acks));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // A wait that runs out counts as a mismatch and ends the run.
  task automatic lim(input int n);
    if (n >= 60) begin
      error_cnt++;
      $display("[FAIL] %0t wait ran out", $time);
      finish_test();
    end
  endtask
  task automatic drv(input logic [27:0] s, input logic e);
    @(posedge ref_clk_i);
    src <= s;
    en <= e;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    awa <= a;
    wd <= d;
    for (n = 0; n < 60 && !(bv && bre); n++) begin
      @(posedge ref_clk_i);
      if (awr && awv) awv <= 1'b0;
      if (wrr && wv) wv <= 1'b0;
    end
    lim(n);
    bre <= 1'b0;
    resp = br;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge ref_clk_i);
    arv <= 1'b1;
    rre <= 1'b1;
    ara <= a;
    for (n = 0; n < 60 && !(rv && rre); n++) begin
      @(posedge ref_clk_i);
      if (arr && arv) arv <= 1'b0;
    end
    lim(n);
    rre <= 1'b0;
    rx = rdat;
    resp = rr;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
    rd(a);
    chk(rx & m, e);
  endtask
  task automatic eoi();
    wr(BIS_EOI_OFS, 32'h0);
  endtask
  task automatic wack(input logic [7:0] v);
    int n;
    na++;
    for (n = 0; n < 60 && acks < na; n++) @(posedge ref_clk_i);
    lim(n);
    chk(acks, na);
    chk(mvec, v);
  endtask
  task automatic t_reset();
    rdc(BIS_MASK_OFS, 32'hff, 32'hff);
    chk({irq, nmi, mcas}, 3'h0);
    rdc(8'h80, 32'hffffffff, 32'h0);
    chk(resp, BIS_RESP_ERR);
    wr(8'h80, 32'h0);
    chk(resp, BIS_RESP_ERR);
    $display("reset test done");
  endtask
  task automatic t_nested();
    for (int k = 0; k < 8; k++) wr(BIS_ROUTE_OFS + 8'(4 * k), 32'h1 << k);
    wr(BIS_CTRL_OFS, 32'h4000);
    wr(BIS_MASK_OFS, 32'h0);
    drv(28'h24, 1'b1);
    wack(8'h42);
    repeat (8) @(posedge ref_clk_i);
    chk(acks, na);
    drv(28'h20, 1'b1);
    eoi();
    wack(8'h45);
    drv(28'h0, 1'b1);
    eoi();
    wr(BIS_MASK_OFS, 32'h4);
    drv(28'h24, 1'b1);
    wack(8'h45);
    drv(28'h0, 1'b1);
    eoi();
    wr(BIS_MASK_OFS, 32'h0);
    $display("nested test done");
  endtask
  task automatic t_rotate();
    wr(BIS_CTRL_OFS, 32'h4001);
    drv(28'h24, 1'b1);
    wack(8'h42);
    eoi();
    wack(8'h45);
    eoi();
    wack(8'h42);
    drv(28'h0, 1'b1);
    eoi();
    $display("rotate test done");
  endtask
  task automatic t_spec();
    wr(BIS_CTRL_OFS, 32'h4016);
    wr(BIS_CASC_OFS, 32'h40);
    drv(28'h44, 1'b1);
    wack(8'h46);
    chk(mcas, 1'b1);
    chk(ca, 3'h6);
    drv(28'h0, 1'b1);
    eoi();
    wr(BIS_CTRL_OFS, 32'h4000);
    drv(28'h44, 1'b1);
    wack(8'h42);
    chk(mcas, 1'b0);
    drv(28'h0, 1'b1);
    eoi();
    $display("specific test done");
  endtask
  task automatic t_polled();
    wr(BIS_CTRL_OFS, 32'h4003);
    drv(28'h8, 1'b1);
    repeat (8) @(posedge ref_clk_i);
    chk(irq, 1'b0);
    rdc(BIS_POLL_OFS, 32'h87, 32'h83);
    rdc(BIS_STAT_OFS, 32'hffff, 32'h808);
    drv(28'h0, 1'b0);
    eoi();
    $display("polled test done");
  endtask
  task automatic t_src();
    for (int k = 0; k < 28; k++) begin
      if (k inside {19, 20, 24, 25, 26}) continue;
      wr(BIS_ROUTE_OFS, 32'h1 << k);
      drv(28'h1 << k, 1'b0);
      rdc(BIS_STAT_OFS, 32'h1, 32'h1);
    end
    wr(BIS_ROUTE_OFS + 8'h20, 32'h100000);
    drv(28'h100000, 1'b0);
    rdc(BIS_STAT_OFS, 32'h1, 32'h0);
    chk(nmi, 1'b0);
    ml <= 1'b1;
    @(posedge ref_clk_i);
    chk(nmi, 1'b1);
    $display("source test done");
  endtask
  task automatic t_or_edge();
    wr(BIS_OR0_OFS, 32'h1800);
    wr(BIS_OR1_OFS, 32'h100);
    wr(BIS_ROUTE_OFS, 32'h2000000);
    drv(28'h1000, 1'b0);
    rdc(BIS_STAT_OFS, 32'h1, 32'h1);
    wr(BIS_ROUTE_OFS, 32'h4000000);
    rdc(BIS_STAT_OFS, 32'h1, 32'h0);
    drv(28'h100, 1'b0);
    rdc(BIS_STAT_OFS, 32'h1, 32'h1);
    wr(BIS_ROUTE_OFS + 8'h4, 32'h1000000);
    drv(28'h1000000, 1'b0);
    drv(28'h0, 1'b0);
    rdc(BIS_STAT_OFS, 32'h3, 32'h2);
    wr(BIS_CTRL_OFS, 32'h4000);
    drv(28'h0, 1'b1);
    wack(8'h41);
    rdc(BIS_STAT_OFS, 32'h2, 32'h0);
    eoi();
    $display("or and edge test done");
  endtask
  task automatic t_tout();
    cmd <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    rdc(BIS_STAT_OFS, 32'h10000, 32'h0);
    repeat (16) @(posedge ref_clk_i);
    rdc(BIS_STAT_OFS, 32'h10000, 32'h10000);
    cmd <= 1'b0;
    wr(BIS_STAT_OFS, 32'h10000);
    rdc(BIS_STAT_OFS, 32'h10000, 32'h0);
    {cmd, xa} <= 2'h3;
    repeat (24) @(posedge ref_clk_i);
    rdc(BIS_STAT_OFS, 32'h10000, 32'h0);
    {cmd, xa} <= 2'h0;
    $display("timeout test done");
  endtask
  task automatic t_misc();
    drv(28'h4000000, 1'b0);
    @(posedge ref_clk_i);
    chk({brn, gnt, po_n}, 3'h3);
    drv(28'h2000000, 1'b0);
    @(posedge ref_clk_i);
    chk(ram_en, 1'b0);
    drv(28'h0, 1'b0);
    @(posedge ref_clk_i);
    chk({ram_en, po_n}, 2'h2);
    wr(BIS_CTRL_OFS, 32'h4020);
    chk(po_n, 1'b1);
    $display("protect and arbitration test done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_nested();
    t_rotate();
    t_spec();
    t_polled();
    t_src();
    t_or_edge();
    t_tout();
    t_misc();
    finish_test();
  end
endmodule // bis_top_test
